// ==== core/pcc_consts.svh ====
// constants for the loop counter and control block
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// divider limits; a zero field stands for the largest value
`define PCC_DIV_ZERO 10'h200
`define PCC_FULL_N_MAX 10'h200
`define PCC_FULL_M_MAX 10'h100
`define PCC_FULL_C_MAX 10'h200
`define PCC_FULL_C_ODD_MAX 10'h100
`define PCC_HS_N_MAX 10'h004
`define PCC_HS_M_MAX 10'h020
`define PCC_HS_C_MAX 10'h020
`define PCC_HS_C_ODD_MAX 10'h010

// feedback pin use
`define PCC_FB_NONE 2'h0
`define PCC_FB_SE 2'h1
`define PCC_FB_DIFF 2'h2
`define PCC_NUM_CTR 6
`define PCC_SEL_LAST 3'h5

// timing: clock period and done pulse length, cycles rounded up
`define PCC_CLK_NS 5
`define PCC_DONE_NS 40
`define PCC_DONE_CYC 4'((`PCC_DONE_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)

// clock-good watchdog and lock detect
`define PCC_BAD_EDGES 3'h4
`define PCC_LOCK_WIN 8'h40
`define PCC_LOCK_N 3'h4

// host register map and fields
`define PCC_REG_CTRL 8'h00
`define PCC_REG_CMD 8'h04
`define PCC_REG_SCAN 8'h08
`define PCC_REG_STATUS 8'h0C
`define PCC_CTRL_RST 14'h0002
`define PCC_CTRL_ARESET 0
`define PCC_CTRL_PFDEN 1
`define PCC_CTRL_USER_LO 8
`define PCC_CTRL_USER_HI 13
`define PCC_CMD_SWITCH 0
`define PCC_CMD_COMMIT 1
`define PCC_SCAN_BITS 5'h10

`endif

// ==== core/pcc_device.sv ====
// loop digital side: dividers, detector, switchover, lock and scan chain
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_device #(
    parameter bit HIGH_SPEED = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic primary_ref_in_i,
    input wire logic secondary_ref_in_i,
    input wire logic pll_ena_i,
    input wire logic [5:0] ext_i,
    output logic [5:0] ext_o,
    output logic [5:0] ext_oe_o,
    pcc_if.dev link
);
    import pcc_pkg::*;

    function automatic logic [9:0] lim(input logic [8:0] v, input logic [9:0] mx);
        logic [9:0] w;
        w = (v == 9'h000) ? `PCC_DIV_ZERO : {1'b0, v};
        return (w > mx) ? mx : w;
    endfunction

    // pins pass two flops; a third stage only feeds edge detection
    logic [3:0] s1_q, s2_q, s3_q;
    logic [3:0] edge_w;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
        end else begin
            s1_q <= {ext_i[0], pll_ena_i, secondary_ref_in_i, primary_ref_in_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign edge_w = s2_q & ~s3_q;

    logic run;
    assign run = s2_q[2] && !link.areset;

    // scan chain and configuration
    localparam int CW = $bits(pcc_cfg_t);
    logic [CW-1:0] chain_q;
    pcc_cfg_t cfg_q;
    logic sclk_prev_q;
    logic done_q;
    logic [3:0] done_cnt_q;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chain_q <= '0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= link.scan_clk;
            if (link.scan_load && link.scan_clk && !sclk_prev_q) begin
                chain_q <= {link.scan_data, chain_q[CW-1:1]};
            end
        end
    end
    assign link.scan_dataout = chain_q[0];

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_q <= '0;
            done_q <= 1'b0;
            done_cnt_q <= 4'h0;
        end else if (link.scan_commit) begin
            cfg_q <= pcc_cfg_t'(chain_q);
            done_q <= 1'b1;
            done_cnt_q <= `PCC_DONE_CYC;
        end else if (done_cnt_q != 4'h0) begin
            done_cnt_q <= done_cnt_q - 4'h1;
            done_q <= (done_cnt_q != 4'h1);
        end
    end
    assign link.scan_done = done_q;

    // effective divide values; out-of-range fields saturate at the limit
    logic [9:0] n_eff, m_eff;
    logic [9:0] div_e [6];
    logic [9:0] hi_e [6];
    always_comb begin
        n_eff = lim(cfg_q.n, HIGH_SPEED ? `PCC_HS_N_MAX : `PCC_FULL_N_MAX);
        m_eff = lim(cfg_q.m, HIGH_SPEED ? `PCC_HS_M_MAX : `PCC_FULL_M_MAX);
        for (int k = 0; k < `PCC_NUM_CTR; k++) begin
            if (cfg_q.ctr[k].odd) begin
                div_e[k] = lim(cfg_q.ctr[k].div, HIGH_SPEED ? `PCC_HS_C_ODD_MAX : `PCC_FULL_C_ODD_MAX);
                hi_e[k] = lim(cfg_q.ctr[k].hi, div_e[k]);
            end else begin
                div_e[k] = lim(cfg_q.ctr[k].div, HIGH_SPEED ? `PCC_HS_C_MAX : `PCC_FULL_C_MAX);
                hi_e[k] = 10'((div_e[k] + 10'h001) >> 1);
            end
        end
    end

    // clock-good watchdog: count edges of the other input since our own
    logic [2:0] gcnt_q [2];
    logic [1:0] good_q;
    logic act_q, loss_q;
    logic sw_cond;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gcnt_q[0] <= 3'h0;
            gcnt_q[1] <= 3'h0;
            good_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (edge_w[i]) begin
                    gcnt_q[i] <= 3'h0;
                end else if (edge_w[1-i] && gcnt_q[i] != `PCC_BAD_EDGES) begin
                    gcnt_q[i] <= gcnt_q[i] + 3'h1;
                end
                good_q[i] <= (gcnt_q[i] != `PCC_BAD_EDGES);
            end
        end
    end
    assign sw_cond = !good_q[act_q];

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            act_q <= 1'b0;
            loss_q <= 1'b0;
        end else begin
            loss_q <= sw_cond;
            if (link.clk_switch) begin
                act_q <= !act_q;
            end else if (!HIGH_SPEED && cfg_q.auto_sw && sw_cond && good_q[!act_q]) begin
                act_q <= !act_q;
            end
        end
    end
    assign link.clk_good = good_q;
    assign link.clk_loss = loss_q;
    assign link.active_clk = act_q;

    // prescale, oscillator phase wheel and feedback divider
    // the oscillator is modelled as eight system cycles, one per phase step
    logic [9:0] ncnt_q, mcnt_q;
    logic [2:0] vco_q;
    logic ref_tick, fb_tick, osc_start;
    assign osc_start = run && vco_q == 3'h0;
    assign ref_tick = run && edge_w[act_q] && ncnt_q == n_eff - 10'h001;
    assign fb_tick = (cfg_q.ext_fb != `PCC_FB_NONE) ? (run && edge_w[3])
                   : (osc_start && mcnt_q == m_eff - 10'h001);
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ncnt_q <= 10'h000;
            mcnt_q <= 10'h000;
            vco_q <= 3'h0;
        end else if (!run) begin
            ncnt_q <= 10'h000;
            mcnt_q <= 10'h000;
            vco_q <= 3'h0;
        end else begin
            vco_q <= vco_q + 3'h1;
            if (edge_w[act_q]) begin
                ncnt_q <= ref_tick ? 10'h000 : ncnt_q + 10'h001;
            end
            if (osc_start) begin
                mcnt_q <= (mcnt_q == m_eff - 10'h001) ? 10'h000 : mcnt_q + 10'h001;
            end
        end
    end

    // phase detector and lock detect
    logic ref_pend_q, fb_pend_q, up_q, down_q, locked_q, match;
    logic [7:0] wait_q;
    logic [2:0] lock_cnt_q;
    assign match = (ref_tick && (fb_tick || fb_pend_q)) || (fb_tick && ref_pend_q);
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_pend_q <= 1'b0;
            fb_pend_q <= 1'b0;
            wait_q <= 8'h00;
            lock_cnt_q <= 3'h0;
        end else if (!run || (!match && wait_q == `PCC_LOCK_WIN)) begin
            ref_pend_q <= 1'b0;
            fb_pend_q <= 1'b0;
            wait_q <= 8'h00;
            lock_cnt_q <= 3'h0;
        end else if (match) begin
            ref_pend_q <= 1'b0;
            fb_pend_q <= 1'b0;
            wait_q <= 8'h00;
            if (lock_cnt_q != `PCC_LOCK_N) begin
                lock_cnt_q <= lock_cnt_q + 3'h1;
            end
        end else begin
            ref_pend_q <= ref_pend_q || ref_tick;
            fb_pend_q <= fb_pend_q || fb_tick;
            if (ref_pend_q || fb_pend_q) begin
                wait_q <= wait_q + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_q <= 1'b0;
            down_q <= 1'b0;
            locked_q <= 1'b0;
        end else begin
            up_q <= link.pfd_en && ref_pend_q;
            down_q <= link.pfd_en && fb_pend_q;
            if (!run) begin
                locked_q <= 1'b0;
            end else begin
                locked_q <= (lock_cnt_q == `PCC_LOCK_N) || (cfg_q.lock_gated && locked_q);
            end
        end
    end
    assign link.up = up_q;
    assign link.down = down_q;
    assign link.locked = locked_q;

    // six post-scale dividers, each stepping on its own phase slot
    logic [9:0] cnt_q [6];
    logic [5:0] c_q;
    for (genvar k = 0; k < `PCC_NUM_CTR; k++) begin : g_post
        logic [9:0] nxt;
        assign nxt = (cnt_q[k] + 10'h001 == div_e[k]) ? 10'h000 : cnt_q[k] + 10'h001;
        always_ff @(posedge sys_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                cnt_q[k] <= 10'h000;
                c_q[k] <= 1'b0;
            end else if (!run) begin
                cnt_q[k] <= 10'h000;
                c_q[k] <= 1'b0;
            end else if (vco_q == cfg_q.ctr[k].phase) begin
                cnt_q[k] <= nxt;
                c_q[k] <= (nxt < hi_e[k]);
            end
        end
    end
    assign link.c = c_q;

    // dedicated pins: any counter, fabric bit or feedback input
    logic [5:0] ext_q, ext_oe_q;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_q <= 6'h00;
            ext_oe_q <= 6'h00;
        end else begin
            for (int p = 0; p < `PCC_NUM_CTR; p++) begin
                ext_oe_q[p] <= !((p == 0 && cfg_q.ext_fb != `PCC_FB_NONE) ||
                                 (p == 1 && cfg_q.ext_fb == `PCC_FB_DIFF));
                if (cfg_q.pin[p].user) begin
                    ext_q[p] <= link.user_out[p] ^ cfg_q.pin[p].inv;
                end else if (cfg_q.pin[p].sel <= `PCC_SEL_LAST) begin
                    ext_q[p] <= c_q[cfg_q.pin[p].sel] ^ cfg_q.pin[p].inv;
                end else begin
                    ext_q[p] <= cfg_q.pin[p].inv;
                end
            end
        end
    end
    assign ext_o = ext_q;
    assign ext_oe_o = ext_oe_q;

endmodule

// ==== core/pcc_host.sv ====
// fabric user logic driving the loop controls from a register port
`timescale 1ns/1ps
`include "pcc_consts.svh"
module pcc_host (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    pcc_if.host link
);
    import pcc_pkg::*;

    logic [13:0] ctrl_q;
    logic sw_q, commit_q;
    logic [15:0] sh_q, rx_q;
    logic [4:0] bit_q;
    logic sclk_q, load_q;
    logic [31:0] rdata_q;
    logic busy;
    assign busy = bit_q != 5'h00;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= `PCC_CTRL_RST;
        end else if (reg_wr_i && reg_addr_i == `PCC_REG_CTRL) begin
            ctrl_q <= reg_wdata_i[13:0];
        end
    end
    assign link.areset = ctrl_q[`PCC_CTRL_ARESET];
    assign link.pfd_en = ctrl_q[`PCC_CTRL_PFDEN];
    assign link.user_out = ctrl_q[`PCC_CTRL_USER_HI:`PCC_CTRL_USER_LO];

    // command pulses last one cycle; a commit written while the shifter is busy is dropped
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sw_q <= 1'b0;
            commit_q <= 1'b0;
        end else begin
            sw_q <= reg_wr_i && reg_addr_i == `PCC_REG_CMD && reg_wdata_i[`PCC_CMD_SWITCH];
            commit_q <= reg_wr_i && reg_addr_i == `PCC_REG_CMD && reg_wdata_i[`PCC_CMD_COMMIT] && !busy;
        end
    end
    assign link.clk_switch = sw_q;
    assign link.scan_commit = commit_q;

    // shifter: two cycles per bit, data set with clock low, clock raised next
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh_q <= 16'h0000;
            rx_q <= 16'h0000;
            bit_q <= 5'h00;
            sclk_q <= 1'b0;
            load_q <= 1'b0;
        end else if (!busy) begin
            sclk_q <= 1'b0;
            load_q <= 1'b0;
            if (reg_wr_i && reg_addr_i == `PCC_REG_SCAN) begin
                sh_q <= reg_wdata_i[15:0];
                bit_q <= `PCC_SCAN_BITS;
                load_q <= 1'b1;
            end
        end else if (!sclk_q) begin
            sclk_q <= 1'b1;
            rx_q <= {link.scan_dataout, rx_q[15:1]};
        end else begin
            sclk_q <= 1'b0;
            sh_q <= {1'b0, sh_q[15:1]};
            bit_q <= bit_q - 5'h01;
            load_q <= (bit_q != 5'h01);
        end
    end
    assign link.scan_clk = sclk_q;
    assign link.scan_load = load_q;
    assign link.scan_data = sh_q[0];

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `PCC_REG_CTRL: rdata_q <= {18'h0_0000, ctrl_q};
                `PCC_REG_SCAN: rdata_q <= {16'h0000, rx_q};
                `PCC_REG_STATUS: rdata_q <= {24'h00_0000, link.down, busy, link.scan_done, link.active_clk,
                                             link.clk_loss, link.clk_good, link.locked};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign reg_rdata_o = rdata_q;

endmodule

// ==== core/pcc_if.sv ====
// link between fabric user logic and the loop
`timescale 1ns/1ps
interface pcc_if;
    logic areset;
    logic pfd_en;
    logic clk_switch;
    logic scan_clk;
    logic scan_data;
    logic scan_load;
    logic scan_commit;
    logic [5:0] user_out;
    logic [5:0] c;
    logic locked;
    logic [1:0] clk_good;
    logic clk_loss;
    logic active_clk;
    logic scan_dataout;
    logic scan_done;
    logic up;
    logic down;

    modport dev (
        input areset, pfd_en, clk_switch, scan_clk, scan_data, scan_load, scan_commit, user_out,
        output c, locked, clk_good, clk_loss, active_clk, scan_dataout, scan_done, up, down
    );
    modport host (
        output areset, pfd_en, clk_switch, scan_clk, scan_data, scan_load, scan_commit, user_out,
        input c, locked, clk_good, clk_loss, active_clk, scan_dataout, scan_done, up, down
    );
endinterface

// ==== core/pcc_pkg.sv ====
// types for the loop counter and control block
package pcc_pkg;

    typedef struct packed {
        logic [2:0] sel;
        logic user;
        logic inv;
    } pcc_pin_t;

    typedef struct packed {
        logic [8:0] div;
        logic [8:0] hi;
        logic odd;
        logic [2:0] phase;
    } pcc_ctr_t;

    typedef struct packed {
        logic [1:0] ext_fb;
        logic lock_gated;
        logic auto_sw;
        pcc_pin_t [5:0] pin;
        pcc_ctr_t [5:0] ctr;
        logic [8:0] m;
        logic [8:0] n;
    } pcc_cfg_t;

endpackage

// ==== test/pcc_link_checker.sv ====
// concurrent checks on the link between fabric logic and the loop
`timescale 1ns/1ps
module pcc_link_checker (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic areset,
    input wire logic pfd_en,
    input wire logic clk_switch,
    input wire logic scan_clk,
    input wire logic scan_data,
    input wire logic scan_load,
    input wire logic scan_commit,
    input wire logic [5:0] c,
    input wire logic locked,
    input wire logic [1:0] clk_good,
    input wire logic clk_loss,
    input wire logic active_clk,
    input wire logic scan_dataout,
    input wire logic scan_done,
    input wire logic up,
    input wire logic down
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic sclk_q;
    logic [1:0] run_q;
    logic shift;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_q <= 1'h0;
        end else begin
            sclk_q <= scan_clk;
        end
    end
    // good flags are forced low in reset, so loss checks wait a few edges
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_q <= 2'h0;
        end else if (run_q != 2'h3) begin
            run_q <= run_q + 2'h1;
        end
    end
    assign shift = scan_load && scan_clk && !sclk_q;
    reset_clear_a: assert property (areset |=> c == 6'h00 && !locked)
        else $error("outputs not cleared under loop reset");
    gate_off_a: assert property (!pfd_en ##1 !pfd_en |-> !up && !down)
        else $error("detector output while gated off");
    switch_pulse_a: assert property (clk_switch |=> !clk_switch && active_clk != $past(active_clk))
        else $error("switch request did not swap source");
    source_hold_a: assert property ($changed(active_clk) |-> $past(clk_switch)
        || ($past(!clk_good[active_clk]) && $past(clk_good[!active_clk]))) else $error("source changed without cause");
    loss_clear_a: assert property (run_q == 2'h3 && clk_good == 2'h3 && $past(clk_good) == 2'h3
        && $stable(active_clk) |-> !clk_loss) else $error("loss flag with both inputs good");
    loss_set_a: assert property (run_q == 2'h3 && !clk_good[active_clk]
        && !$past(clk_good[active_clk]) && $stable(active_clk) |-> clk_loss) else $error("loss flag missing");
    shift_out_a: assert property ($changed(scan_dataout) |-> $past(shift))
        else $error("serial output moved without a shift");
    shift_hold_a: assert property (scan_load && scan_clk |-> $stable(scan_data) ##1 !scan_clk)
        else $error("serial data unstable around shift edge");
    commit_done_a: assert property (scan_commit |=> scan_done)
        else $error("commit not followed by done");
    done_length_a: assert property ($fell(scan_done) |-> $past(scan_done, 8))
        else $error("done fell too early");
    done_cause_a: assert property ($rose(scan_done) |-> $past(scan_commit))
        else $error("done rose without commit");
endmodule

// ==== test/test_pll_counter_and_control.sv ====
// self-checking bench for both ends of the loop control link
`timescale 1ns/1ps
`include "pcc_consts.svh"
module test_pll_counter_and_control;
    import pcc_pkg::*;
    typedef struct {
        logic [31:0] e;
        logic [31:0] m;
        string n;
    } pcc_note_t;
    logic sys_clk_i = 1'h0;
    logic nrst_i = 1'h0;
    logic prim_ref = 1'h0;
    logic sec_ref = 1'h0;
    logic prim_run = 1'h1;
    logic sec_run = 1'h1;
    logic pll_ena = 1'h0;
    logic [5:0] ext_in = 6'h00;
    logic [5:0] ext_out;
    logic [5:0] ext_oe;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic rd_q = 1'h0;
    logic [31:0] rdata;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    integer seed = 32'h8f93_d16e;
    pcc_note_t notes[$];
    pcc_note_t nt;
    pcc_cfg_t cfg;
    logic [191:0] bits;
    logic [5:0] inv;
    logic [5:0] u;
    pcc_if link ();
    pcc_device i_pcc_device (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .primary_ref_in_i(prim_ref),
        .secondary_ref_in_i(sec_ref), .pll_ena_i(pll_ena), .ext_i(ext_in), .ext_o(ext_out),
        .ext_oe_o(ext_oe), .link(link));
    pcc_host i_pcc_host (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .link(link));
    pcc_link_checker i_pcc_link_checker (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .areset(link.areset),
        .pfd_en(link.pfd_en), .clk_switch(link.clk_switch), .scan_clk(link.scan_clk),
        .scan_data(link.scan_data), .scan_load(link.scan_load), .scan_commit(link.scan_commit),
        .c(link.c), .locked(link.locked), .clk_good(link.clk_good), .clk_loss(link.clk_loss),
        .active_clk(link.active_clk), .scan_dataout(link.scan_dataout), .scan_done(link.scan_done),
        .up(link.up), .down(link.down));
    always #2.5 sys_clk_i = ~sys_clk_i;
    task automatic finish_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            $display("unexpected %s: expected %h, seen %h", n, e, s);
            n_mismatch++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge sys_clk_i);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
        notes.push_back('{e, m, n});
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'h1;
        @(posedge sys_clk_i);
        rd <= 1'h0;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask
    // reference pins stand still while stopped, which is what a dead oscillator looks like
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        ext_in <= cycles[7:2];
        if (prim_run && cycles % 3 == 0) prim_ref <= ~prim_ref;
        if (sec_run && cycles % 4 == 0) sec_ref <= ~sec_ref;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // read data stand only in the cycle after the strobe
    always @(posedge sys_clk_i) begin
        rd_q <= rd;
        if (rd_q) begin
            nt = notes.pop_front();
            chk(nt.n, rdata & nt.m, nt.e & nt.m);
        end
    end
    initial begin
        idle(5);
        nrst_i <= 1'h1;
        rd_reg(`PCC_REG_CTRL, 32'h0000_0002, 32'hffff_ffff, "ctrl reset");
        rd_reg(`PCC_REG_CMD, 32'h0, 32'hffff_ffff, "cmd read");
        rd_reg(8'h10, 32'h0, 32'hffff_ffff, "unmapped read");
        rd_reg(`PCC_REG_STATUS, 32'h0000_0006, 32'h0000_007f, "status reset");
        u = 6'($random(seed));
        wr_reg(`PCC_REG_CTRL, {18'h0, u, 8'h03});
        rd_reg(`PCC_REG_CTRL, {18'h0, u, 8'h03}, 32'h0000_3f03, "ctrl");
        wr_reg(`PCC_REG_CTRL, {18'h0, u, 8'h00});
        pll_ena <= 1'h1;
        idle(20);
        wr_reg(`PCC_REG_CTRL, 32'h0000_0002);
        idle(40);
        wr_reg(`PCC_REG_CMD, 32'h0000_0001);
        idle(4);
        rd_reg(`PCC_REG_STATUS, 32'h0000_0016, 32'h0000_001e, "secondary active");
        sec_run <= 1'h0;
        idle(60);
        rd_reg(`PCC_REG_STATUS, 32'h0000_001a, 32'h0000_001e, "secondary lost");
        sec_run <= 1'h1;
        idle(40);
        wr_reg(`PCC_REG_CMD, 32'h0000_0001);
        prim_run <= 1'h0;
        idle(60);
        rd_reg(`PCC_REG_STATUS, 32'h0000_000c, 32'h0000_001e, "primary lost");
        // loop reset while the counters run must pull them all low
        wr_reg(`PCC_REG_CTRL, 32'h0000_0003);
        idle(2);
        chk("counters in reset", {26'h0, link.c}, 32'h0);
        wr_reg(`PCC_REG_CTRL, 32'h0000_0002);
        prim_run <= 1'h1;
        pll_ena <= 1'h0;
        idle(8);
        repeat (4) begin
            @(posedge sys_clk_i);
            chk("counters off", {26'h0, link.c}, 32'h0);
        end
        pll_ena <= 1'h1;
        idle(40);
        cfg = '0;
        cfg.ext_fb = `PCC_FB_DIFF;
        cfg.auto_sw = 1'h1;
        for (int p = 0; p < 6; p++) begin
            cfg.pin[p].user = 1'h1;
            cfg.pin[p].inv = 1'($random(seed));
            cfg.ctr[p].div = 9'($random(seed));
            inv[p] = cfg.pin[p].inv;
        end
        // eight filler bits go first and fall off the far end of the chain
        bits = {cfg, 8'($random(seed))};
        for (int k = 0; k < 12; k++) begin
            wr_reg(`PCC_REG_SCAN, {16'h0, bits[16*k +: 16]});
            idle(36);
        end
        rd_reg(`PCC_REG_SCAN, {16'h0, bits[7:0], 8'h00}, 32'h0000_ff00, "scan out");
        wr_reg(`PCC_REG_CMD, 32'h0000_0002);
        idle(12);
        chk("pin enables", {26'h0, ext_oe}, 32'h0000_003c);
        for (int r = 0; r < 2; r++) begin
            u = 6'($random(seed));
            wr_reg(`PCC_REG_CTRL, {18'h0, u, 8'h02});
            idle(6);
            chk("pin levels", {26'h0, ext_out & 6'h3c}, {26'h0, (u ^ inv) & 6'h3c});
        end
        rd_reg(`PCC_REG_STATUS, 32'h0, 32'h0000_0020, "done low");
        // full variant with auto switch on: losing the active input moves to the good one
        prim_run <= 1'h0;
        idle(60);
        rd_reg(`PCC_REG_STATUS, 32'h0000_0014, 32'h0000_001e, "auto switch");
        idle(3);
        finish_test();
    end
endmodule
